// >>> hdl/three_source_irq_control.v
// interrupt control for three request sources with vectors and flag stack
//
// Contract
// - three sources, fixed priority: 8-bit timer, pin edge, tick timer
// - accepted request branches to vector 0003h, 0002h or 0001h
// - simultaneous enabled requests are accepted one by one by priority
// - unmask-all sets the global latch, mask-all clears it
// - acceptance clears the global latch, so nesting waits for an unmask-all
// - unmask-all takes effect after the following instruction completes
// - acceptance pushes five status flags on a three-deep stack
// - request flag sets on its event and clears on acceptance
// - each request flag has its own enable flag
// - global latch is never readable by software
// - reset clears the global latch
// - pin request flag sets on the selected pin edge
// - timer events drive their own separate request flags
// - pin-level flag mirrors the external pin
// - polarity flag: 0 rising edge, 1 falling edge
// - software may write request flags to raise or cancel requests
// - acceptance only at instruction boundaries, after second cycle if two-cycle
// - lower requests wait until an unmask-all, even inside a higher handler
// - acceptance and return each take one instruction cycle
`timescale 1ns/1ps
`include "irq_ctrl_defs.vh"
module three_source_irq_control #(
	parameter STACK_DEPTH = `STACK_DEPTH   // saved flag levels
) (
	input  wire        i_clk,             // system clock, 40 MHz
	input  wire        i_resetn,          // sync reset, active low
	input  wire        i_ce,              // clock enable
	input  wire        i_timer8_event,    // 8-bit timer match pulse
	input  wire        i_tick_event,      // interval timer pulse
	input  wire        i_ext_pin,         // external request pin
	input  wire        i_instr_end,       // pulse: instruction cycle boundary
	input  wire        i_second_pending,  // current instr needs a second cycle
	input  wire        i_unmask_all,      // pulse: unmask-all executed
	input  wire        i_mask_all,        // pulse: mask-all executed
	input  wire        i_ret_handler,     // pulse: return from handler
	input  wire        i_ack,             // pulse: core starts acceptance cycle
	input  wire [4:0]  i_core_flags,      // decimal, compare, carry, zero, index-enable
	input  wire        i_req_wr,          // write request flags
	input  wire [2:0]  i_req_wdata,       // {timer8, pin, tick} request values
	input  wire        i_en_wr,           // write enable flags
	input  wire [2:0]  i_en_wdata,        // {timer8, pin, tick} enable values
	input  wire        i_pol_wr,          // write edge polarity
	input  wire        i_pol_wdata,       // 0 rising, 1 falling
	output reg  [2:0]  o_req_flags,       // request flags, readable
	output reg  [2:0]  o_en_flags,        // enable flags, readable
	output reg         o_edge_polarity,   // polarity flag, readable
	output wire        o_pin_level,       // pin-level flag
	output wire        o_irq,             // request to core, combinational
	output reg  [13:0] o_vector,          // vector of accepted source
	output reg  [4:0]  o_restore_flags,   // flags popped on return
	output reg         o_restore_valid,   // pulse: restore data valid
	output reg  [1:0]  o_stack_level,     // saved levels in use
	output reg         o_stack_overflow   // push while stack full
);
	reg        global_enable_q;    // never on any read port
	reg        arm_pending_q;      // unmask-all waiting one instruction
	reg        arm_stage_q;
	reg [4:0]  stack_q [0:STACK_DEPTH-1];
	wire       pin_edge;
	wire [2:0] active;
	wire [2:0] grant;
	wire [2:0] set_evt;
	integer    k;

	// priority pick: highest set bit wins
	function [2:0] pick_highest;
		input [2:0] v;
		begin
			if (v[`SRC_TIMER8])
				pick_highest = 3'h4;
			else if (v[`SRC_PIN_EDGE])
				pick_highest = 3'h2;
			else if (v[`SRC_TICK_TIMER])
				pick_highest = 3'h1;
			else
				pick_highest = 3'h0;
		end
	endfunction

	pin_edge_detect u_pin (
		.i_clk     (i_clk),
		.i_resetn  (i_resetn),
		.i_ce      (i_ce),
		.i_pin     (i_ext_pin),
		.i_falling (o_edge_polarity),
		.o_level   (o_pin_level),
		.o_edge    (pin_edge)
	);

	// source events
	assign set_evt = {i_timer8_event, pin_edge, i_tick_event};
	assign active  = o_req_flags & o_en_flags;
	assign grant   = pick_highest(active);
	// request whenever an enabled flag is pending with the latch open, not gated by any boundary
	assign o_irq   = global_enable_q & (|active);

	// global latch with one-instruction arming delay
	always @(posedge i_clk) begin
		if (!i_resetn) begin
			global_enable_q <= `GLOBAL_EN_RST;
			arm_pending_q   <= 1'b0;
			arm_stage_q     <= 1'b0;
		end else if (i_ce) begin
			if (i_mask_all) begin
				global_enable_q <= 1'b0;
				arm_pending_q   <= 1'b0;
				arm_stage_q     <= 1'b0;
			end else if (i_ack) begin
				// acceptance also drops any arming still in progress
				global_enable_q <= 1'b0;
				arm_pending_q   <= 1'b0;
				arm_stage_q     <= 1'b0;
			end else if (i_unmask_all) begin
				arm_pending_q <= 1'b1;
				arm_stage_q   <= 1'b0;
			end else if (arm_pending_q && i_instr_end && !i_second_pending) begin
				// first boundary ends unmask-all, second ends the next instr
				if (arm_stage_q) begin
					global_enable_q <= 1'b1;
					arm_pending_q   <= 1'b0;
					arm_stage_q     <= 1'b0;
				end else begin
					arm_stage_q <= 1'b1;
				end
			end
		end
	end

	// request, enable and polarity flags
	always @(posedge i_clk) begin
		if (!i_resetn) begin
			o_req_flags     <= `REQ_FLAGS_RST;
			o_en_flags      <= `EN_FLAGS_RST;
			o_edge_polarity <= `EDGE_RISING;
		end else if (i_ce) begin
			// software write first, then clear on accept, then events win
			for (k = 0; k < 3; k = k + 1) begin
				if (set_evt[k])
					o_req_flags[k] <= 1'b1;
				else if (i_ack && grant[k])
					o_req_flags[k] <= 1'b0;
				else if (i_req_wr)
					o_req_flags[k] <= i_req_wdata[k];
			end
			if (i_en_wr)
				o_en_flags <= i_en_wdata;
			if (i_pol_wr)
				o_edge_polarity <= i_pol_wdata;
		end
	end

	// vector register, loaded in the acceptance cycle
	always @(posedge i_clk) begin
		if (!i_resetn) begin
			o_vector <= 14'h0000;
		end else if (i_ce && i_ack) begin
			case (grant)
				3'h4: o_vector <= `VEC_TIMER8;
				3'h2: o_vector <= `VEC_PIN_EDGE;
				3'h1: o_vector <= `VEC_TICK_TIMER;
				default: o_vector <= o_vector;
			endcase
		end
	end

	// three-level flag stack: push on accept, pop on return
	always @(posedge i_clk) begin
		if (!i_resetn) begin
			o_stack_level    <= 2'h0;
			o_stack_overflow <= 1'b0;
			o_restore_flags  <= 5'h00;
			o_restore_valid  <= 1'b0;
			for (k = 0; k < STACK_DEPTH; k = k + 1)
				stack_q[k] <= 5'h00;
		end else if (i_ce) begin
			o_restore_valid <= 1'b0;
			if (i_ack) begin
				// data buffer and working register are not saved here
				if (o_stack_level < STACK_DEPTH[1:0]) begin
					stack_q[o_stack_level] <= i_core_flags;
					o_stack_level <= o_stack_level + 2'h1;
				end else begin
					o_stack_overflow <= 1'b1;
				end
			end else if (i_ret_handler && o_stack_level != 2'h0) begin
				o_restore_flags <= stack_q[o_stack_level - 2'h1];
				o_restore_valid <= 1'b1;
				o_stack_level   <= o_stack_level - 2'h1;
			end
		end
	end
endmodule

// >>> hdl/irq_ctrl_defs.vh
// constants for the three-source interrupt control block
`ifndef IRQ_CTRL_DEFS_VH
`define IRQ_CTRL_DEFS_VH
`define VEC_TIMER8      14'h0003
`define VEC_PIN_EDGE    14'h0002
`define VEC_TICK_TIMER  14'h0001
`define SRC_TIMER8      2
`define SRC_PIN_EDGE    1
`define SRC_TICK_TIMER  0
`define EDGE_RISING     1'b0
`define EDGE_FALLING    1'b1
`define GLOBAL_EN_RST   1'b0
`define REQ_FLAGS_RST   3'h0
`define EN_FLAGS_RST    3'h0
`define STACK_DEPTH     3
`define SAVE_FLAGS_W    5
`define VEC_W           14
`endif

// >>> hdl/pin_edge_detect.v
// synchroniser and selectable edge detector for the external request pin
`timescale 1ns/1ps
module pin_edge_detect (
	input  wire i_clk,        // system clock
	input  wire i_resetn,     // sync reset, active low
	input  wire i_ce,         // clock enable
	input  wire i_pin,        // raw external request pin
	input  wire i_falling,    // edge polarity select
	output wire o_level,      // synchronised pin level
	output wire o_edge        // one-cycle pulse on selected edge
);
	reg meta_q;
	reg sync_q;
	reg prev_q;

	// two-stage synchroniser plus history stage
	always @(posedge i_clk) begin
		if (!i_resetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else if (i_ce) begin
			meta_q <= i_pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// edge select on synchronised level only
	assign o_level = sync_q;
	assign o_edge  = i_ce & (i_falling ? (prev_q & ~sync_q) : (~prev_q & sync_q));
endmodule

// >>> bench/irq_ctrl_sva.sv
// assertion checker for the interrupt control ports
`timescale 1ns/1ps
module irq_ctrl_sva (
	input wire		i_clk,
	input wire		i_resetn,
	input wire		i_ce,
	input wire		i_ack,
	input wire		i_mask_all,
	input wire		i_tick_event,
	input wire		i_ext_pin,
	input wire [2:0]	o_req_flags,
	input wire [2:0]	o_en_flags,
	input wire		o_irq,
	input wire		o_pin_level,
	input wire [13:0]	o_vector,
	input wire [1:0]	o_stack_level
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// pending and enabled sources
	wire [2:0] w = o_req_flags & o_en_flags;
	sequence s_acc; i_ce && i_ack && o_irq; endsequence
	a_irq_pair: assert property (o_irq |-> w != 3'h0) else $error("irq without pair");
	a_vec_top: assert property (s_acc ##0 w[2] |=> o_vector == 14'h0003) else $error("top vector");
	a_vec_low: assert property (s_acc ##0 w == 3'h1 |=> o_vector == 14'h0001) else $error("low vector");
	a_ack_block: assert property (s_acc |=> !o_irq) else $error("nested request");
	a_ack_push: assert property (s_acc ##0 o_stack_level != 2'h3 |=>
		o_stack_level == $past(o_stack_level) + 2'h1) else $error("no push");
	a_mask_all: assert property (i_ce && i_mask_all |=> !o_irq) else $error("mask ignored");
	a_tick_set: assert property (i_ce && i_tick_event |=> o_req_flags[0]) else $error("tick lost");
	a_pin_level: assert property ($past(i_resetn) && $past(i_resetn, 2) && $past(i_ce) &&
		$past(i_ce, 2) |-> o_pin_level == $past(i_ext_pin, 2)) else $error("pin level");
	a_reset_idle: assert property (disable iff (1'b0) !i_resetn && i_ce |=>
		!o_irq && o_req_flags == 3'h0) else $error("reset state");
endmodule

// >>> bench/core_seq_model.sv
// core sequencer model: boundaries and acceptance cycles
`timescale 1ns/1ps
module core_seq_model (
	input wire	i_clk,		// system clock
	input wire	i_resetn,	// sync reset, active low
	input wire	i_slow,		// boundary every 4 cycles
	input wire	i_second,	// two-cycle instruction pending
	input wire	i_irq,		// request from the block
	output reg	o_end = 1'b0,	// boundary pulse
	output reg	o_ack = 1'b0	// acceptance cycle
);
	reg [1:0] cnt_q;
	// accept only right after a completed boundary
	always @(posedge i_clk) begin
		cnt_q <= i_resetn ? cnt_q + 2'h1 : 2'h0;
		o_end <= i_resetn && (i_slow ? &cnt_q : cnt_q[0]);
		o_ack <= i_resetn && o_end && !i_second && i_irq;
	end
endmodule

// >>> bench/tb_top.sv
// self-checking bench for the interrupt control block
`timescale 1ns/1ps
module tb_top;
	reg i_clk = 0, i_resetn = 0, i_ce = 1, i_ext_pin = 0, i_second_pending = 0, slow = 0;
	reg i_timer8_event = 0, i_tick_event = 0, i_unmask_all = 0, i_mask_all = 0, i_ret_handler = 0;
	reg i_req_wr = 0, i_en_wr = 0, i_pol_wr = 0, i_pol_wdata = 0;
	reg [2:0] i_req_wdata = 0, i_en_wdata = 0, sh;
	reg [4:0] i_core_flags = 0;
	reg [31:0] r;
	wire i_instr_end, i_ack, o_edge_polarity, o_pin_level, o_irq, o_restore_valid, o_stack_overflow;
	wire [2:0] o_req_flags, o_en_flags;
	wire [1:0] o_stack_level;
	wire [4:0] o_restore_flags;
	wire [13:0] o_vector;
	integer n_fail = 0, comparisons = 0, seed = 32'h52cc, e, b, m_req, m_en, m_pol, m_lat, u, m_vec, m_rf, m_rv;
	integer m_ov;
	integer stk[$];
	three_source_irq_control dut (.*);
	core_seq_model core (.i_clk(i_clk), .i_resetn(i_resetn), .i_slow(slow),
		.i_second(i_second_pending), .i_irq(o_irq), .o_end(i_instr_end), .o_ack(i_ack));
	always #12.5 i_clk = ~i_clk;
	// reference model of flags, latch, stack and pin path
	always @(posedge i_clk) begin
		if (!i_resetn) begin
			{m_req, m_en, m_pol, m_lat, u, m_vec, m_rv, m_ov} = 0;
			sh = 0;
			stk = {};
		end else if (i_ce) begin
			e = m_pol ? sh[2] & ~sh[1] : sh[1] & ~sh[2];
			sh = {sh[1:0], i_ext_pin};
			b = m_req & m_en;
			b = b[2] ? 4 : b[1] ? 2 : b[0];
			m_rv = 0;
			if (i_instr_end && !i_second_pending && u > 0) begin
				u = u - 1;
				if (u == 0) m_lat = 1;
			end
			if (i_unmask_all) u = 2;
			if (i_req_wr) m_req = i_req_wdata;
			if (i_ack) begin
				m_req = m_req & ~b;
				if (b != 0) m_vec = b == 4 ? 3 : b;
				{m_lat, u} = 0;
				if (stk.size() < 3) stk.push_back(i_core_flags);
				else m_ov = 1;
			end
			if (i_mask_all) {m_lat, u} = 0;
			if (i_ret_handler && !i_ack && stk.size() > 0) begin
				m_rf = stk.pop_back();
				m_rv = 1;
			end
			if (i_en_wr) m_en = i_en_wdata;
			if (i_pol_wr) m_pol = i_pol_wdata;
			m_req = m_req | i_timer8_event << 2 | e << 1 | i_tick_event;
		end
	end
	// compare once outputs have settled
	always @(negedge i_clk) if (i_resetn) begin
		cmp(o_req_flags, m_req);
		cmp(o_en_flags, m_en);
		cmp(o_edge_polarity, m_pol);
		cmp(o_pin_level, sh[1]);
		cmp(o_irq, m_lat && (m_req & m_en) != 0);
		cmp(o_stack_level, stk.size());
		cmp(o_stack_overflow, m_ov);
		cmp(o_restore_valid, m_rv);
		if (m_rv) cmp(o_restore_flags, m_rf);
		cmp(o_vector, m_vec);
	end
	task cmp(input [13:0] g, input integer x);
		begin
			comparisons = comparisons + 1;
			if (g !== x[13:0]) begin
				n_fail = n_fail + 1;
				$display("MISMATCH %0t got %h want %h", $time, g, x[13:0]);
			end
		end
	endtask
	// core pulse (0 unmask, 1 mask, 2 return) in the cycle after a boundary
	task op(input integer k);
		begin
			@(negedge i_clk);
			while (!i_instr_end) @(negedge i_clk);
			@(negedge i_clk);
			{i_ret_handler, i_mask_all, i_unmask_all} = 3'h1 << k;
			@(negedge i_clk);
			{i_ret_handler, i_mask_all, i_unmask_all} = 3'h0;
		end
	endtask
	task report_and_stop;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, n_fail);
			if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	// main sequence
	initial begin
		repeat (10) @(negedge i_clk);
		i_resetn = 1;
		@(negedge i_clk);
		{i_en_wr, i_en_wdata, i_req_wr, i_req_wdata} = 8'hff;
		@(negedge i_clk);
		{i_en_wr, i_req_wr} = 0;
		repeat (3) begin
			i_core_flags = $random(seed);
			op(0);
			@(posedge i_ack);
		end
		repeat (3) op(2);
		$display("nested priority test done");
		repeat (20) begin
			op(1);
			repeat (12) begin
				@(negedge i_clk);
				r = $random(seed);
				{i_timer8_event, i_tick_event, i_req_wr, i_en_wr, i_pol_wr} = r[4:0] & r[9:5] & r[14:10];
				{i_req_wdata, i_en_wdata, i_pol_wdata, i_second_pending, slow} = r[23:15];
				i_ext_pin = i_ext_pin ^ (r[24] & r[25]);
				i_core_flags = r[30:26];
				i_ce = ~(r[31] & r[29] & r[27]);
			end
			@(negedge i_clk);
			{i_timer8_event, i_tick_event, i_req_wr, i_en_wr, i_pol_wr, i_second_pending} = 0;
			i_ce = 1;
			op(0);
			op(2);
			repeat (10) @(negedge i_clk);
		end
		$display("random traffic test done");
		report_and_stop;
	end
	// hang guard well beyond the expected run
	initial begin
		#(25 * 20000);
		n_fail = n_fail + 1;
		report_and_stop;
	end
endmodule
bind three_source_irq_control irq_ctrl_sva sva_chk (.*);
